/* hdl/bmidt_decode.sv */
// Function
// [RULE1] accumulator ops: twelve periods, one or two bytes
// [RULE2] logic into direct with immediate: 3 bytes, 24
// [RULE3] pointer load constant: 3 bytes, 24 periods
// [RULE4] external moves: one byte, 24, 8/16-bit address
// [RULE5] code table read: accumulator plus base, 24
// [RULE6] direct-direct 3 bytes; register-direct 2 bytes; 24
// [RULE7] push and pop: two bytes, 24 periods
// [RULE8] nibble swap and low digit exchange: 12
// [RULE9] carry-bit logic 24/2 bytes; carry alone 12
// [RULE10] test-clear branch jumps when set, clears bit
// [RULE11] compare branch unequal: three bytes, 24 periods
// [RULE12] decrement branch nonzero: 2 or 3 bytes
// [RULE13] relative offset signed, from next instruction
// [RULE14] page target 11 bits within next 2K page
// [RULE15] long target full 16 bits
// [RULE16] direct below 128 RAM, else special register
// [RULE17] index pointer addresses RAM 0-255; the low digit exchange flags 128-255 as special register
// [RULE18] bank register picks one of eight in bank
// [RULE19] flags byte or bit writes update flags
// [RULE20] indirect jump to accumulator plus pointer
// [RULE21] conditional branches 24; flag tests 2 bytes
// [RULE22] carry, excess and nibble carry updated per op; only direct and immediate adds set all three, compares set carry alone
// Purpose: classify an instruction, build operand addresses and targets, time execution
// Assumes: the caller presents a whole instruction with its operand bytes and data values
// Notes: a busy pulse spans the execution time; done pulses on its last cycle
`timescale 1ns/1ps
module bmidt_decode
  import bmidt_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  input wire logic start_in,
  input wire bmidt_class_t class_in,
  input wire logic [2:0] sub_op_in,
  input wire logic [7:0] byte1_in,
  input wire logic [7:0] byte2_in,
  input wire logic [7:0] byte3_in,
  input wire logic [15:0] pc_in,
  input wire logic [7:0] acc_in,
  input wire logic [7:0] operand_in,
  input wire logic [15:0] sixteen_bit_pointer_in,
  input wire logic [7:0] index_pointer_operand_in,
  input wire logic bit_value_in,
  input wire logic flags_write_in,
  input wire logic [7:0] flags_write_addr_in,
  input wire logic [7:0] flags_write_data_in,
  output logic busy_out,
  output logic done_out,
  output logic [1:0] length_out,
  output logic [5:0] periods_out,
  output logic [7:0] ram_addr_out,
  output logic sfr_select_out,
  output logic [15:0] mem_addr_out,
  output logic [15:0] next_pc_out,
  output logic branch_taken_out,
  output logic clear_bit_out,
  output logic [7:0] result_out,
  output logic [7:0] program_flags_word_out
);
  // ****************************************************************
  // functions
  // ****************************************************************
  function automatic logic [15:0] rel_target(input logic [15:0] nxt, input logic [7:0] off);
    rel_target = nxt + {{8{off[7]}}, off}; // [RULE13]
  endfunction

  function automatic logic [1:0] byte_len(input bmidt_class_t c, input logic [2:0] s);
    case (c)
      BMIDT_ALU_DIR, BMIDT_ALU_IMM, BMIDT_MOV_REG_DIR, BMIDT_PUSH, BMIDT_POP,
      BMIDT_CARRY_BIT, BMIDT_DEC_REG, BMIDT_SHORT_REL, BMIDT_PAGE, BMIDT_COND_FLAG:
        byte_len = 2'h2;
      BMIDT_LOG_DIR_IMM, BMIDT_LOAD_PTR, BMIDT_MOV_DIR_DIR, BMIDT_TEST_CLEAR,
      BMIDT_CMP_IMM, BMIDT_CMP_DIR, BMIDT_DEC_DIR, BMIDT_LONG, BMIDT_COND_BIT:
        byte_len = 2'h3;
      default:
        byte_len = 2'h1;
    endcase
  endfunction

  function automatic logic long_exec(input bmidt_class_t c);
    case (c)
      BMIDT_NOP, BMIDT_ALU_REG, BMIDT_ALU_DIR, BMIDT_ALU_IND, BMIDT_ALU_IMM,
      BMIDT_SWAP, BMIDT_LOW_DIGIT_XCH, BMIDT_CARRY_ONLY:
        long_exec = 1'b0;
      default:
        long_exec = 1'b1;
    endcase
  endfunction

  // ****************************************************************
  // decode
  // ****************************************************************
  localparam logic [5:0] ONE_CYCLE = 6'(PERIODS_PER_CYCLE);
  logic [7:0] program_flags_word_reg;
  wire logic [1:0] len_w = byte_len(class_in, sub_op_in); // [RULE1] [RULE2] [RULE3] [RULE6]
  wire logic two_cycle_w = long_exec(class_in); // [RULE4] [RULE5] [RULE7] [RULE8] [RULE9]
  wire logic [15:0] next_w = pc_in + {14'h0000, len_w};
  wire logic [15:0] ind_target_w = sixteen_bit_pointer_in + {8'h00, acc_in}; // [RULE20]
  wire logic [15:0] page_target_w = {next_w[15:11], sub_op_in, byte2_in}; // [RULE14]
  wire logic [15:0] long_target_w = {byte2_in, byte3_in}; // [RULE15]
  wire logic [2:0] bank_w = {1'b0, program_flags_word_reg[4:3]};
  wire logic [7:0] bank_addr_w = {3'h0, bank_w[1:0], sub_op_in}; // [RULE18]
  wire logic [7:0] cmp_val_w = (class_in == BMIDT_CMP_IMM) ? byte2_in : operand_in;
  wire logic cmp_ne_w = (acc_in != cmp_val_w); // [RULE11]
  wire logic [7:0] dec_w = operand_in - 8'h01;
  wire logic dec_nz_w = (dec_w != 8'h00); // [RULE12]
  wire logic [7:0] rel_w = (len_w == 2'h3) ? byte3_in : byte2_in;
  wire logic cond_flag_w = sub_op_in[1] ? ((acc_in == 8'h00) ^ sub_op_in[0])
                                        : (program_flags_word_reg[FLAG_CY] ^ sub_op_in[0]);
  wire logic [8:0] add_w = {1'b0, acc_in} + {1'b0, operand_in} +
                           {8'h00, sub_op_in[0] & program_flags_word_reg[FLAG_CY]};
  wire logic [4:0] nib_w = {1'b0, acc_in[3:0]} + {1'b0, operand_in[3:0]} +
                           {4'h0, sub_op_in[0] & program_flags_word_reg[FLAG_CY]};
  wire logic ov_w = (acc_in[7] == operand_in[7]) && (add_w[7] != acc_in[7]);
  wire logic flags_hit_w = flags_write_in && (flags_write_addr_in == FLAGS_BYTE_ADDR);
  wire logic flag_bit_hit_w = flags_write_in && (flags_write_addr_in >= FLAGS_BIT_LO) &&
                              (flags_write_addr_in <= FLAGS_BIT_HI);

  logic taken_w;
  logic [15:0] target_w;
  logic [7:0] addr_w;
  logic [15:0] mem_w;
  logic [7:0] res_w;
  always_comb
  begin
    taken_w = 1'b0;
    target_w = next_w;
    addr_w = byte2_in; // [RULE16]
    mem_w = 16'h0000;
    res_w = acc_in;
    case (class_in)
      BMIDT_ALU_REG, BMIDT_MOV_REG_DIR, BMIDT_DEC_REG: addr_w = bank_addr_w;
      BMIDT_ALU_IND, BMIDT_LOW_DIGIT_XCH: addr_w = index_pointer_operand_in; // [RULE17]
      default: addr_w = byte2_in;
    endcase
    // address, memory and result decodes are separate so no class shadows another
    case (class_in)
      BMIDT_EXT_IDX: mem_w = {8'h00, index_pointer_operand_in}; // [RULE4]
      BMIDT_EXT_PTR: mem_w = sixteen_bit_pointer_in; // [RULE4]
      BMIDT_CODE_PTR: mem_w = ind_target_w; // [RULE5]
      BMIDT_CODE_PC: mem_w = next_w + {8'h00, acc_in}; // [RULE5]
      BMIDT_LOAD_PTR: mem_w = long_target_w; // [RULE3]
      default: mem_w = 16'h0000;
    endcase
    case (class_in)
      BMIDT_SWAP: res_w = {acc_in[3:0], acc_in[7:4]}; // [RULE8]
      BMIDT_LOW_DIGIT_XCH: res_w = {acc_in[7:4], operand_in[3:0]}; // [RULE8]
      BMIDT_ALU_DIR, BMIDT_ALU_IMM: res_w = add_w[7:0];
      BMIDT_LOG_DIR_IMM: // [RULE2]
      begin
        case (sub_op_in[1:0])
          2'h0: res_w = operand_in & byte3_in;
          2'h1: res_w = operand_in | byte3_in;
          default: res_w = operand_in ^ byte3_in;
        endcase
      end
      BMIDT_DEC_REG, BMIDT_DEC_DIR: res_w = dec_w; // [RULE12]
      default: res_w = acc_in;
    endcase
    case (class_in)
      BMIDT_SHORT_REL:
      begin
        taken_w = 1'b1;
        target_w = rel_target(next_w, rel_w);
      end
      BMIDT_PAGE:
      begin
        taken_w = 1'b1;
        target_w = page_target_w;
      end
      BMIDT_LONG:
      begin
        taken_w = 1'b1;
        target_w = long_target_w;
      end
      BMIDT_IND_JUMP:
      begin
        taken_w = 1'b1;
        target_w = ind_target_w;
      end
      BMIDT_TEST_CLEAR, BMIDT_COND_BIT, BMIDT_COND_FLAG, BMIDT_CMP_IMM, BMIDT_CMP_DIR,
      BMIDT_DEC_REG, BMIDT_DEC_DIR:
      begin
        case (class_in)
          BMIDT_TEST_CLEAR: taken_w = bit_value_in; // [RULE10]
          BMIDT_COND_BIT: taken_w = bit_value_in ^ sub_op_in[0]; // [RULE21]
          BMIDT_COND_FLAG: taken_w = cond_flag_w; // [RULE21]
          BMIDT_CMP_IMM, BMIDT_CMP_DIR: taken_w = cmp_ne_w; // [RULE11]
          default: taken_w = dec_nz_w; // [RULE12]
        endcase
        if (taken_w)
        begin
          target_w = rel_target(next_w, rel_w);
        end
      end
      default: taken_w = 1'b0;
    endcase
  end

  // ****************************************************************
  // flags
  // ****************************************************************
  logic [7:0] program_flags_word_next;
  always_comb
  begin
    program_flags_word_next = program_flags_word_reg;
    // a start while busy is refused, so it must not touch the flags either
    if (start_in && (state_reg == BMIDT_ST_IDLE))
    begin
      case (class_in)
        BMIDT_ALU_DIR, BMIDT_ALU_IMM: // [RULE22]
        begin
          program_flags_word_next[FLAG_CY] = add_w[8];
          program_flags_word_next[FLAG_AC] = nib_w[4];
          program_flags_word_next[FLAG_OV] = ov_w;
        end
        BMIDT_CARRY_ONLY: // [RULE9]
        begin
          case (sub_op_in[1:0])
            2'h0: program_flags_word_next[FLAG_CY] = 1'b0;
            2'h1: program_flags_word_next[FLAG_CY] = 1'b1;
            default: program_flags_word_next[FLAG_CY] = ~program_flags_word_reg[FLAG_CY];
          endcase
        end
        BMIDT_CARRY_BIT: // [RULE9]
          program_flags_word_next[FLAG_CY] = sub_op_in[0]
            ? (program_flags_word_reg[FLAG_CY] | (bit_value_in ^ sub_op_in[1]))
            : (program_flags_word_reg[FLAG_CY] & (bit_value_in ^ sub_op_in[1]));
        BMIDT_CMP_IMM, BMIDT_CMP_DIR: // [RULE22]
          program_flags_word_next[FLAG_CY] = (acc_in < cmp_val_w);
        default: program_flags_word_next = program_flags_word_reg;
      endcase
    end
    // a direct write lands after the instruction's own flag effect
    if (flags_hit_w)
    begin
      program_flags_word_next = flags_write_data_in; // [RULE19]
    end
    else if (flag_bit_hit_w)
    begin
      program_flags_word_next[flags_write_addr_in[2:0]] = flags_write_data_in[0]; // [RULE19]
    end
  end

  // ****************************************************************
  // timing
  // ****************************************************************
  bmidt_state_t state_reg;
  bmidt_state_t state_next;
  logic [5:0] count_reg;
  logic [5:0] count_next;
  wire logic [5:0] total_w = two_cycle_w ? (ONE_CYCLE + ONE_CYCLE) : ONE_CYCLE;
  always_comb
  begin
    state_next = state_reg;
    count_next = count_reg;
    case (state_reg)
      BMIDT_ST_IDLE:
      begin
        if (start_in)
        begin
          state_next = BMIDT_ST_RUN;
          count_next = total_w - 6'h01;
        end
      end
      BMIDT_ST_RUN:
      begin
        count_next = count_reg - 6'h01;
        if (count_reg == 6'h01)
        begin
          state_next = BMIDT_ST_DONE;
        end
      end
      BMIDT_ST_DONE: state_next = BMIDT_ST_IDLE;
      default: state_next = BMIDT_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      state_reg <= BMIDT_ST_IDLE;
      count_reg <= 6'h00;
      program_flags_word_reg <= FLAGS_RESET;
    end
    else
    begin
      state_reg <= state_next;
      count_reg <= count_next;
      program_flags_word_reg <= program_flags_word_next;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      length_out <= 2'h0;
      periods_out <= 6'h00;
      ram_addr_out <= 8'h00;
      sfr_select_out <= 1'b0;
      mem_addr_out <= 16'h0000;
      next_pc_out <= 16'h0000;
      branch_taken_out <= 1'b0;
      clear_bit_out <= 1'b0;
      result_out <= 8'h00;
    end
    else if (start_in && state_reg == BMIDT_ST_IDLE)
    begin
      length_out <= len_w;
      periods_out <= total_w;
      ram_addr_out <= addr_w;
      sfr_select_out <= (addr_w >= SFR_BASE) && (class_in != BMIDT_ALU_IND); // [RULE16] [RULE17]
      mem_addr_out <= mem_w;
      next_pc_out <= target_w;
      branch_taken_out <= taken_w;
      clear_bit_out <= (class_in == BMIDT_TEST_CLEAR) && bit_value_in; // [RULE10]
      result_out <= res_w;
    end
  end

  assign busy_out = (state_reg != BMIDT_ST_IDLE);
  assign done_out = (state_reg == BMIDT_ST_DONE);
  assign program_flags_word_out = program_flags_word_reg;
endmodule // bmidt_decode

/* hdl/bmidt_pkg.sv */
// Purpose: constants for the byte core instruction decode and timing block
// Assumes: one machine cycle is twelve oscillator periods
// Notes: opcode values are the block's own encoding of the documented instruction classes
package bmidt_pkg;
  localparam int unsigned PERIODS_PER_CYCLE = 12;
  localparam logic [7:0] SFR_BASE = 8'h80;
  localparam logic [7:0] FLAGS_BYTE_ADDR = 8'hD0;
  localparam logic [7:0] FLAGS_BIT_LO = 8'hD1;
  localparam logic [7:0] FLAGS_BIT_HI = 8'hD7;
  localparam logic [4:0] BANK_BIT_POS = 5'h03;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam int unsigned FLAG_CY = 7;
  localparam int unsigned FLAG_AC = 6;
  localparam int unsigned FLAG_OV = 2;
  typedef enum logic [5:0] {
    BMIDT_NOP = 6'h00, BMIDT_ALU_REG = 6'h01, BMIDT_ALU_DIR = 6'h02,
    BMIDT_ALU_IND = 6'h03, BMIDT_ALU_IMM = 6'h04, BMIDT_LOG_DIR_IMM = 6'h05,
    BMIDT_LOAD_PTR = 6'h06, BMIDT_EXT_IDX = 6'h07, BMIDT_EXT_PTR = 6'h08,
    BMIDT_CODE_PTR = 6'h09, BMIDT_CODE_PC = 6'h0A, BMIDT_MOV_DIR_DIR = 6'h0B,
    BMIDT_MOV_REG_DIR = 6'h0C, BMIDT_PUSH = 6'h0D, BMIDT_POP = 6'h0E,
    BMIDT_SWAP = 6'h0F, BMIDT_LOW_DIGIT_XCH = 6'h10, BMIDT_CARRY_BIT = 6'h11,
    BMIDT_CARRY_ONLY = 6'h12, BMIDT_TEST_CLEAR = 6'h13, BMIDT_CMP_IMM = 6'h14,
    BMIDT_CMP_DIR = 6'h15, BMIDT_DEC_REG = 6'h16, BMIDT_DEC_DIR = 6'h17,
    BMIDT_SHORT_REL = 6'h18, BMIDT_PAGE = 6'h19, BMIDT_LONG = 6'h1A,
    BMIDT_IND_JUMP = 6'h1B, BMIDT_COND_FLAG = 6'h1C, BMIDT_COND_BIT = 6'h1D
  } bmidt_class_t;
  typedef enum logic [1:0] {
    BMIDT_ST_IDLE = 2'b00, BMIDT_ST_RUN = 2'b01, BMIDT_ST_DONE = 2'b11
  } bmidt_state_t;
endpackage

/* testbench/bmidt_asserts.sv */
// Purpose: port-level timing and target properties of the decode block
// Assumes: a start counts only while busy is low
// Notes: the long-op done window allows one cycle of slack either way; the short-op window allows two cycles early, none late
`timescale 1ns/1ps
module bmidt_asserts
  import bmidt_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  input wire logic start_in,
  input wire bmidt_class_t class_in,
  input wire logic [2:0] sub_op_in,
  input wire logic [7:0] byte2_in,
  input wire logic [7:0] byte3_in,
  input wire logic [15:0] pc_in,
  input wire logic busy_out,
  input wire logic done_out,
  input wire logic [1:0] length_out,
  input wire logic [5:0] periods_out,
  input wire logic [15:0] next_pc_out
);
  logic acc_w;
  logic [15:0] pc2_w;
  assign acc_w = start_in && !busy_out;
  assign pc2_w = pc_in + 16'h0002;
  default clocking dc @(posedge clk_sys_in);
  endclocking
  default disable iff (!rst_b_in);
  property p_alu_len;
    acc_w && class_in == BMIDT_ALU_REG |=> length_out == 2'h1 && periods_out == 6'h0c;
  endproperty
  a_alu_len: assert property (p_alu_len) else $error("alu size wrong");
  property p_log_len;
    acc_w && class_in == BMIDT_LOG_DIR_IMM |=> length_out == 2'h3 && periods_out == 6'h18;
  endproperty
  a_log_len: assert property (p_log_len) else $error("logic direct size wrong");
  property p_ptr_len;
    acc_w && class_in == BMIDT_LOAD_PTR |=> length_out == 2'h3 && periods_out == 6'h18;
  endproperty
  a_ptr_len: assert property (p_ptr_len) else $error("pointer load size wrong");
  property p_done_12;
    acc_w ##1 periods_out == 6'h0c |-> !done_out [*8] ##[2:4] done_out;
  endproperty
  a_done_12: assert property (p_done_12) else $error("short op done late");
  property p_done_24;
    acc_w ##1 periods_out == 6'h18 |-> ##[22:24] done_out;
  endproperty
  a_done_24: assert property (p_done_24) else $error("long op done late");
  property p_rel;
    acc_w && class_in == BMIDT_SHORT_REL |=>
      next_pc_out == $past(pc2_w) + {{8{$past(byte2_in[7])}}, $past(byte2_in)};
  endproperty
  a_rel: assert property (p_rel) else $error("relative target wrong");
  property p_page;
    acc_w && class_in == BMIDT_PAGE |=>
      next_pc_out == {$past(pc2_w[15:11]), $past(sub_op_in), $past(byte2_in)};
  endproperty
  a_page: assert property (p_page) else $error("page target wrong");
  property p_long;
    acc_w && class_in == BMIDT_LONG |=> next_pc_out == {$past(byte2_in), $past(byte3_in)};
  endproperty
  a_long: assert property (p_long) else $error("long target wrong");
endmodule // bmidt_asserts

bind bmidt_decode bmidt_asserts u_chk (.*);

/* testbench/bmidt_prog_mem.sv */
// Purpose: program memory model handing out instruction bytes
// Assumes: a combinational read of three bytes from the fetch address
// Notes: contents are an address hash, so every fetch is repeatable
`timescale 1ns/1ps
module bmidt_prog_mem (
  input wire logic [15:0] addr_in,
  output logic [7:0] byte1_out,
  output logic [7:0] byte2_out,
  output logic [7:0] byte3_out
);
  assign byte1_out = addr_in[7:0] ^ addr_in[15:8] ^ 8'h5a;
  assign byte2_out = 8'(addr_in + 16'h0001) ^ addr_in[14:7];
  assign byte3_out = 8'(addr_in + 16'h0002) ^ addr_in[15:8] ^ 8'ha7;
endmodule // bmidt_prog_mem

/* testbench/byte_mcu_instr_decode_timing_test.sv */
// Purpose: self-checking bench for the instruction decode block
// Assumes: one start per execution, outputs stand until the next start
// Notes: every class runs twice in the loop (the register add once more before it); the second pass uses boundary operands
`timescale 1ns/1ps
module byte_mcu_instr_decode_timing_test;
  import bmidt_pkg::*;
  logic clk_sys_in = 1'b0, rst_b_in = 1'b0, start_in = 1'b0, bit_value_in = 1'b0;
  logic flags_write_in = 1'b0;
  bmidt_class_t class_in = BMIDT_NOP;
  logic [2:0] sub_op_in = 3'h0;
  logic [15:0] pc_in = 16'h0000, sixteen_bit_pointer_in = 16'h0000;
  logic [7:0] acc_in = 8'h00, operand_in = 8'h00, index_pointer_operand_in = 8'h00;
  logic [7:0] flags_write_addr_in = 8'h00, flags_write_data_in = 8'h00;
  wire logic busy_out, done_out, sfr_select_out, branch_taken_out, clear_bit_out;
  wire logic [7:0] byte1_in, byte2_in, byte3_in, ram_addr_out, result_out;
  wire logic [7:0] program_flags_word_out;
  wire logic [15:0] mem_addr_out, next_pc_out;
  wire logic [1:0] length_out;
  wire logic [5:0] periods_out;
  int err_count = 0;
  int n_checks = 0;
  integer seed = 32'hb3fd_434d;
  // byte count and long-time flag per class, indexed by class code
  string len_tab = "112123311113222112133323223123";
  string per_tab = "000001111111111001011111111111";
  bmidt_decode dut (.*);
  bmidt_prog_mem mem (.addr_in(pc_in), .byte1_out(byte1_in), .byte2_out(byte2_in),
    .byte3_out(byte3_in));
  always #2 clk_sys_in = ~clk_sys_in;
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e)
    begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic flag_wr(input logic [7:0] a, input logic [7:0] d);
    flags_write_in = 1'b1;
    flags_write_addr_in = a;
    flags_write_data_in = d;
    @(negedge clk_sys_in);
    flags_write_in = 1'b0;
  endtask
  task automatic run(input bmidt_class_t c, input logic [2:0] s);
    int i;
    logic [15:0] p;
    p = (per_tab[c] == "1") ? 16'h0018 : 16'h000c;
    class_in = c;
    sub_op_in = s;
    start_in = 1'b1;
    @(negedge clk_sys_in);
    start_in = 1'b0;
    i = 1;
    while (done_out !== 1'b1 && i < 40)
    begin
      @(negedge clk_sys_in);
      i++;
    end
    if (i >= 40)
    begin
      err_count++;
      report_and_stop();
    end
    chk("length", 16'(len_tab[c] - 8'h30), 16'(length_out));
    chk("periods", p, 16'(periods_out));
    chk("cycles", p, 16'(i));
    @(negedge clk_sys_in);
  endtask
  initial
  begin
    bmidt_class_t c;
    logic [2:0] s;
    logic [15:0] nx;
    repeat (20) @(negedge clk_sys_in);
    rst_b_in = 1'b1;
    chk("flags reset", 16'(FLAGS_RESET), 16'(program_flags_word_out));
    flag_wr(FLAGS_BYTE_ADDR, 8'h18);
    chk("flags byte", 16'h0018, 16'(program_flags_word_out));
    flag_wr(8'hd3, 8'h00);
    chk("flags bit", 16'h0010, 16'(program_flags_word_out));
    run(BMIDT_ALU_REG, 3'h5);
    chk("bank reg", 16'h0015, 16'(ram_addr_out));
    for (int k = 0; k < 60; k++)
    begin
      c = bmidt_class_t'(k % 30);
      s = 3'($random(seed));
      pc_in = 16'($random(seed));
      acc_in = 8'($random(seed));
      operand_in = (k < 30) ? 8'($random(seed)) : 8'h01;
      sixteen_bit_pointer_in = 16'($random(seed));
      index_pointer_operand_in = 8'($random(seed));
      bit_value_in = k[0];
      #1;
      nx = pc_in + 16'h0002;
      if (c == BMIDT_CMP_IMM)
        acc_in = (k < 30) ? ~byte2_in : byte2_in;
      if (c == BMIDT_CMP_IMM)
        operand_in = acc_in;
      run(c, s);
      case (c)
        BMIDT_SHORT_REL: chk("rel", nx + {{8{byte2_in[7]}}, byte2_in}, next_pc_out);
        BMIDT_PAGE: chk("page", {nx[15:11], s, byte2_in}, next_pc_out);
        BMIDT_LONG: chk("long", {byte2_in, byte3_in}, next_pc_out);
        BMIDT_IND_JUMP: chk("jump", sixteen_bit_pointer_in + 16'(acc_in), next_pc_out);
        BMIDT_ALU_DIR: chk("direct", {byte2_in[7], byte2_in}, {sfr_select_out, ram_addr_out});
        BMIDT_ALU_IND: chk("indirect", 16'(index_pointer_operand_in), 16'(ram_addr_out));
        BMIDT_EXT_PTR: chk("ext ptr", sixteen_bit_pointer_in, mem_addr_out);
        BMIDT_EXT_IDX: chk("ext idx", 16'(index_pointer_operand_in), 16'(mem_addr_out[7:0]));
        BMIDT_CODE_PTR: chk("table", sixteen_bit_pointer_in + 16'(acc_in), mem_addr_out);
        BMIDT_TEST_CLEAR: chk("tclr", {2{bit_value_in}}, {branch_taken_out, clear_bit_out});
        BMIDT_CMP_IMM: chk("compare", 16'(k < 30), 16'(branch_taken_out));
        BMIDT_DEC_REG: chk("dec", {operand_in != 8'h01, operand_in - 8'h01},
          {branch_taken_out, result_out});
        BMIDT_SWAP: chk("swap", 16'({acc_in[3:0], acc_in[7:4]}), 16'(result_out));
        default: ;
      endcase
    end
    report_and_stop();
  end
endmodule // byte_mcu_instr_decode_timing_test
